/* File: pkg/lfes_map.svh */
`ifndef LFES_MAP_SVH
`define LFES_MAP_SVH
// ************************************************************
// Field encodings
// ************************************************************
// Output filter select codes
`define LFES_FILT_NONE 2'h0
`define LFES_FILT_SYNC 2'h1
`define LFES_FILT_PERS 2'h2
// Clock source codes
`define LFES_PERIPHERAL_CLOCK 3'h0
`define LFES_CLK_IN2 3'h1
// Sequencer select codes
`define LFES_SEQ_OFF 4'h0
`define LFES_SEQ_DFF 4'h1
`define LFES_SEQ_JK 4'h2
`define LFES_SEQ_LAT 4'h3
`define LFES_SEQ_RS 4'h4
// Interrupt edge mode codes
`define LFES_INT_NONE 2'h0
`define LFES_INT_RISE 2'h1
`define LFES_INT_FALL 2'h2
`define LFES_INT_BOTH 2'h3
// Field widths
`define LFES_FILT_W 2
`define LFES_CSRC_W 3
`define LFES_SEQ_W 4
`define LFES_INTM_W 2
`endif

/* File: pkg/lfes_pkg.sv */
// ************************************************************
// Shared types
// ************************************************************
package lfes_pkg;
`include "lfes_map.svh"
  // Sequencer function
  typedef enum logic [`LFES_SEQ_W-1:0] {
    LFES_SEQ_OFF_E = `LFES_SEQ_OFF,
    LFES_SEQ_DFF_E = `LFES_SEQ_DFF,
    LFES_SEQ_JK_E = `LFES_SEQ_JK,
    LFES_SEQ_LAT_E = `LFES_SEQ_LAT,
    LFES_SEQ_RS_E = `LFES_SEQ_RS
  } lfes_seq_mode_t;
endpackage : lfes_pkg

/* File: hdl/lfes_seq.sv */
`timescale 1ns/1ps
// ************************************************************
// Pair sequencer
// ************************************************************
module lfes_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controls
  input wire logic tick,
  input wire logic clr,
  input wire logic [3:0] mode,
  // Data from even and odd paths
  input wire logic even_in,
  input wire logic odd_in,
  // State
  output logic q
);
  // Sequencer state, cleared asynchronously by clr pulse
  always_ff @(posedge clk or negedge rst_n or posedge clr) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (clr) begin
      q <= 1'b0;
    end else begin
      case (mode)
        lfes_pkg::LFES_SEQ_DFF_E: begin
          if (tick && odd_in) q <= even_in;
        end
        lfes_pkg::LFES_SEQ_JK_E: begin
          if (tick) begin
            case ({even_in, odd_in})
              2'h1: q <= 1'b0;
              2'h2: q <= 1'b1;
              2'h3: q <= ~q;
              default: q <= q;
            endcase
          end
        end
        lfes_pkg::LFES_SEQ_LAT_E: begin
          if (odd_in) q <= even_in;
        end
        lfes_pkg::LFES_SEQ_RS_E: begin
          // Both high is forbidden; hold state then
          if (even_in && !odd_in) q <= 1'b1;
          else if (odd_in && !even_in) q <= 1'b0;
        end
        default: q <= 1'b0;
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_jk_toggle;
    @(posedge clk) disable iff (!rst_n || clr)
    (mode == lfes_pkg::LFES_SEQ_JK_E && tick && even_in && odd_in)
      |=> (q != $past(q));
  endproperty
  a_jk_toggle: assert property (p_jk_toggle)
    else $error("JK toggle failed");
  property p_dff_hold;
    @(posedge clk) disable iff (!rst_n || clr)
    (mode == lfes_pkg::LFES_SEQ_DFF_E && !(tick && odd_in))
      |=> $stable(q);
  endproperty
  a_dff_hold: assert property (p_dff_hold)
    else $error("DFF changed without gate");
  c_jk: cover property (@(posedge clk)
    mode == lfes_pkg::LFES_SEQ_JK_E && tick && even_in && odd_in);
endmodule : lfes_seq

/* File: hdl/lfes_top.sv */
`timescale 1ns/1ps
// Operation
// - no filter gives combinational LUT output
// - sync mode delays two selected clock edges
// - persistence filter passes stable values, delay four
// - filter state cleared cycle after disable
// - edge detector pulses on rising input
// - edge state cleared cycle after disable
// - each pair feeds one selectable sequencer
// - sequencer select is four-bit coded field
// - DFF and JK sequencers use even LUT clock, rising edge
// - even disable clears sequencer for one cycle
// - DFF loads even when odd gate high
// - JK holds, clears, sets or toggles
// - D latch follows even while gate high
// - RS latch sets or clears, never both
// - default clock is peripheral, else local clock
// - third input clocks LUT, reads low
// - flags per edge mode, ORed level request
// - output level event, event inputs passed raw
// - standby without keep running forces zero on LUTs with a clocked stage
// - idle sleep keeps truth output live
// - config changes only while even LUT disabled
`include "lfes_map.svh"
module lfes_top #(
  parameter int N = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Truth-table core
  input wire logic [N-1:0] lut_comb_in,
  input wire logic [N-1:0] lut_third_input,
  output logic [N-1:0] lut_third_mask_q,
  // Event inputs and outputs
  input wire logic [N-1:0] event_a_in,
  input wire logic [N-1:0] event_b_in,
  output logic [N-1:0] event_a_to_truth,
  output logic [N-1:0] event_b_to_truth,
  output logic [N-1:0] lut_event_out,
  // LUT configuration
  input wire logic [N-1:0] lut_enable,
  input wire logic [N*`LFES_FILT_W-1:0] output_filter_select,
  input wire logic [N-1:0] edge_detect_enable,
  input wire logic [N*`LFES_CSRC_W-1:0] lut_clock_source,
  input wire logic [N/2*`LFES_SEQ_W-1:0] pair_sequencer_select,
  // Interrupts
  input wire logic [N*`LFES_INTM_W-1:0] interrupt_edge_mode,
  input wire logic [N-1:0] flag_clear,
  output logic [N-1:0] lut_interrupt_flag,
  output logic irq_q,
  // Sleep
  input wire logic standby_sleep,
  input wire logic standby_keep_running,
  // LUT outputs
  output logic [N-1:0] lut_out
);
  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (N < 2 || N % 2 != 0) begin : g_bad_n
    $error("N must be even and at least 2");
  end

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [N-1:0] en_q; // Registered enables
  logic [N-1:0] t1_q; // Third input sync stage 1
  logic [N-1:0] t2_q; // Third input sync stage 2
  logic [N-1:0] t3_q; // Previous synced third input
  logic [N-1:0] tick; // Selected clock edge per LUT
  logic [N-1:0] s0_q; // Filter stage 0
  logic [N-1:0] s1_q; // Filter stage 1
  logic [N-1:0] s2_q; // Filter stage 2
  logic [N-1:0] pers_q; // Persistence output
  logic [N-1:0] prev_q; // Edge detector history
  logic [N-1:0] edge_q; // Edge pulse
  logic [N-1:0] filt_v; // Filtered value
  logic [N-1:0] path_v; // After edge detector
  logic [N-1:0] busy_v; // Clocked stage in use
  logic [N-1:0] fin_v; // Final LUT output
  logic [N-1:0] last_q; // Previous final output
  logic [N-1:0] flag_set; // Flag set events
  logic [N-1:0] int_on; // Interrupt source enabled
  logic [N-1:0] edet_q; // Shadow edge enable
  logic [N*`LFES_FILT_W-1:0] fsel_q; // Shadow filter select
  logic [N*`LFES_CSRC_W-1:0] csrc_q; // Shadow clock source
  logic [N/2*`LFES_SEQ_W-1:0] ssel_q; // Shadow sequencer select
  logic [N/2-1:0] clr_q; // Sequencer clear pulse
  logic [N/2-1:0] seq_q; // Sequencer outputs
  logic run_ok; // Clock runs in this sleep state

  // Clock halts in standby unless kept running
  assign run_ok = !standby_sleep || standby_keep_running;

  // Event inputs go to the core untouched
  assign event_a_to_truth = event_a_in;
  assign event_b_to_truth = event_b_in;

  // Level event mirrors the LUT output
  assign lut_event_out = fin_v;
  assign lut_out = fin_v;

  // ************************************************************
  // Enable register and third input synchroniser
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= '0;
      t1_q <= '0;
      t2_q <= '0;
      t3_q <= '0;
    end else begin
      en_q <= lut_enable;
      t1_q <= lut_third_input;
      t2_q <= t1_q;
      t3_q <= t2_q;
    end
  end

  // ************************************************************
  // Per-LUT path
  // ************************************************************
  for (genvar i = 0; i < N; i++) begin : g_lut
    localparam int E = (i / 2) * 2;
    localparam int P = i / 2;
    logic [`LFES_FILT_W-1:0] fsel;
    logic [`LFES_CSRC_W-1:0] csrc;
    logic [`LFES_INTM_W-1:0] imode;
    logic seq_on;
    assign fsel = fsel_q[i*`LFES_FILT_W +: `LFES_FILT_W];
    assign csrc = csrc_q[i*`LFES_CSRC_W +: `LFES_CSRC_W];
    assign imode = interrupt_edge_mode[i*`LFES_INTM_W +: `LFES_INTM_W];
    assign seq_on = ssel_q[P*`LFES_SEQ_W +: `LFES_SEQ_W] != `LFES_SEQ_OFF;

    // Shadow config, writable only while even LUT is off
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        fsel_q[i*`LFES_FILT_W +: `LFES_FILT_W] <= `LFES_FILT_NONE;
        csrc_q[i*`LFES_CSRC_W +: `LFES_CSRC_W] <= `LFES_PERIPHERAL_CLOCK;
        edet_q[i] <= 1'b0;
        lut_third_mask_q[i] <= 1'b0;
      end else if (!en_q[E]) begin
        fsel_q[i*`LFES_FILT_W +: `LFES_FILT_W] <=
          output_filter_select[i*`LFES_FILT_W +: `LFES_FILT_W];
        csrc_q[i*`LFES_CSRC_W +: `LFES_CSRC_W] <=
          lut_clock_source[i*`LFES_CSRC_W +: `LFES_CSRC_W];
        edet_q[i] <= edge_detect_enable[i];
        // Third input reads low when used as clock
        lut_third_mask_q[i] <= lut_clock_source[i*`LFES_CSRC_W +:
          `LFES_CSRC_W] == `LFES_CLK_IN2;
      end
    end

    // Selected clock: every cycle or synced third input rise
    always_comb begin
      if (csrc == `LFES_CLK_IN2) begin
        tick[i] = run_ok && t2_q[i] && !t3_q[i];
      end else begin
        tick[i] = run_ok;
      end
    end

    // Synchroniser and persistence filter
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s0_q[i] <= 1'b0;
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        pers_q[i] <= 1'b0;
      end else if (!en_q[i]) begin
        s0_q[i] <= 1'b0;
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        pers_q[i] <= 1'b0;
      end else if (tick[i]) begin
        s0_q[i] <= lut_comb_in[i];
        s1_q[i] <= s0_q[i];
        s2_q[i] <= s1_q[i];
        // Pass only a value seen on three edges
        if (s0_q[i] == s1_q[i] && s1_q[i] == s2_q[i]) begin
          pers_q[i] <= s2_q[i];
        end
      end
    end

    // Filter output select
    always_comb begin
      case (fsel)
        `LFES_FILT_SYNC: filt_v[i] = s1_q[i];
        `LFES_FILT_PERS: filt_v[i] = pers_q[i];
        default: filt_v[i] = lut_comb_in[i];
      endcase
    end

    // Rising edge detector, pulse one tick long
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        prev_q[i] <= 1'b0;
        edge_q[i] <= 1'b0;
      end else if (!en_q[i]) begin
        prev_q[i] <= 1'b0;
        edge_q[i] <= 1'b0;
      end else if (tick[i]) begin
        prev_q[i] <= filt_v[i];
        edge_q[i] <= filt_v[i] && !prev_q[i];
      end
    end

    // Edge path or filter path
    assign path_v[i] = edet_q[i] ? edge_q[i] : filt_v[i];

    // Any clocked stage in use on this LUT
    assign busy_v[i] = fsel != `LFES_FILT_NONE || edet_q[i] ||
      (i == E && seq_on);

    // Final output: standby force, sequencer on even LUT
    always_comb begin
      if (!en_q[i]) begin
        fin_v[i] = 1'b0;
      end else if (!run_ok && busy_v[i]) begin
        fin_v[i] = 1'b0;
      end else if (i == E && seq_on) begin
        fin_v[i] = seq_q[P];
      end else begin
        fin_v[i] = path_v[i];
      end
    end

    // Interrupt flag set condition
    always_comb begin
      case (imode)
        `LFES_INT_RISE: flag_set[i] = fin_v[i] && !last_q[i];
        `LFES_INT_FALL: flag_set[i] = !fin_v[i] && last_q[i];
        `LFES_INT_BOTH: flag_set[i] = fin_v[i] != last_q[i];
        default: flag_set[i] = 1'b0;
      endcase
    end
    assign int_on[i] = imode != `LFES_INT_NONE;
  end

  // ************************************************************
  // Sequencers, one per pair
  // ************************************************************
  for (genvar p = 0; p < N / 2; p++) begin : g_pair
    // Shadow select and clear pulse on even disable
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ssel_q[p*`LFES_SEQ_W +: `LFES_SEQ_W] <= `LFES_SEQ_OFF;
        clr_q[p] <= 1'b0;
      end else begin
        if (!en_q[2*p]) begin
          ssel_q[p*`LFES_SEQ_W +: `LFES_SEQ_W] <=
            pair_sequencer_select[p*`LFES_SEQ_W +: `LFES_SEQ_W];
        end
        clr_q[p] <= en_q[2*p] && !lut_enable[2*p];
      end
    end

    lfes_seq u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick[2*p]),
      .clr(clr_q[p]),
      .mode(ssel_q[p*`LFES_SEQ_W +: `LFES_SEQ_W]),
      .even_in(path_v[2*p]),
      .odd_in(path_v[2*p+1]),
      .q(seq_q[p])
    );
  end

  // ************************************************************
  // Interrupt flags and request
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= '0;
      lut_interrupt_flag <= '0;
      irq_q <= 1'b0;
    end else begin
      last_q <= fin_v;
      // Set wins over a clear in the same cycle
      lut_interrupt_flag <= (lut_interrupt_flag & ~flag_clear) |
        flag_set;
      irq_q <= |(lut_interrupt_flag & int_on);
    end
  end

  // ************************************************************
  // Checks on sample LUTs
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bypass;
    (en_q[1] && fsel_q[3:2] == `LFES_FILT_NONE && !edet_q[1])
      |-> lut_out[1] == lut_comb_in[1];
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Bypass output not combinational");

  property p_sync;
    (en_q[0] && tick[0]) [*2]
      |=> s1_q[0] == $past(lut_comb_in[0], 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("Sync stage wrong delay");

  property p_pers;
    (en_q[4] && tick[4] && lut_comb_in[4]) [*4]
      |=> pers_q[4];
  endproperty
  a_pers: assert property (p_pers)
    else $error("Stable high not passed");

  property p_filt_clr;
    !en_q[0] |=> !s0_q[0] && !s1_q[0] && !s2_q[0] && !pers_q[0];
  endproperty
  a_filt_clr: assert property (p_filt_clr)
    else $error("Filter not cleared");

  property p_edge;
    $rose(edge_q[0]) |-> $past(filt_v[0]) && !$past(prev_q[0]);
  endproperty
  a_edge: assert property (p_edge)
    else $error("Pulse without rising edge");

  property p_edge_clr;
    !en_q[0] |=> !edge_q[0] && !prev_q[0];
  endproperty
  a_edge_clr: assert property (p_edge_clr)
    else $error("Edge state not cleared");

  property p_clr_len;
    clr_q[0] |=> !clr_q[0];
  endproperty
  a_clr_len: assert property (p_clr_len)
    else $error("Sequencer clear not one cycle");

  property p_irq;
    ##1 irq_q == $past(|(lut_interrupt_flag & int_on));
  endproperty
  a_irq: assert property (p_irq)
    else $error("Request not tracking flags");

  property p_set_wins;
    flag_set[1] && flag_clear[1] |=> lut_interrupt_flag[1];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Flag set lost to clear");

  property p_standby;
    !run_ok && busy_v[0] |-> !lut_out[0];
  endproperty
  a_standby: assert property (p_standby)
    else $error("Output not forced low in standby");

  property p_protect;
    en_q[0] |=> $stable(fsel_q[1:0]) && $stable(ssel_q[3:0]);
  endproperty
  a_protect: assert property (p_protect)
    else $error("Protected config changed");

  c_edge: cover property ($rose(edge_q[0]));
  c_pers: cover property ($rose(pers_q[4]));
  c_irq: cover property ($rose(irq_q));
  c_seq: cover property ($rose(seq_q[0]));
endmodule : lfes_top

/* File: tb/lfes_top_tb_top.sv */
`timescale 1ns/1ps
`include "lfes_map.svh"
// ********************
// Stage bench
// ********************
module lfes_top_tb_top;
  localparam int N = 6;
  // Clock and reset
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  // Core and event inputs
  logic [N-1:0] lut_comb_in = '0;
  logic [N-1:0] lut_third_input = '0;
  logic [N-1:0] event_a_in = '0;
  logic [N-1:0] event_b_in = '0;
  // Configuration
  logic [N-1:0] lut_enable = '0;
  logic [2*N-1:0] output_filter_select = '0;
  logic [N-1:0] edge_detect_enable = '0;
  logic [3*N-1:0] lut_clock_source = '0;
  logic [4*(N/2)-1:0] pair_sequencer_select = '0;
  logic [2*N-1:0] interrupt_edge_mode = '0;
  logic [N-1:0] flag_clear = '0;
  logic standby_sleep = 1'b0;
  logic standby_keep_running = 1'b0;
  // Outputs
  logic [N-1:0] lut_third_mask_q;
  logic [N-1:0] event_a_to_truth;
  logic [N-1:0] event_b_to_truth;
  logic [N-1:0] lut_event_out;
  logic [N-1:0] lut_interrupt_flag;
  logic irq_q;
  logic [N-1:0] lut_out;
  // Expectation notes
  typedef struct {
    int kind;
    int idx;
    logic [N-1:0] exp;
  } lfes_note_t;
  lfes_note_t notes_q[$];
  lfes_note_t cur;
  event chk_ev;
  int num_errors = 0;
  int samples_checked = 0;
  int unsigned seed;
  logic [N-1:0] pulses;
  // Sequencer modes and steps of even, odd, expected
  logic [3:0] seq_mode [5] = '{`LFES_SEQ_DFF, `LFES_SEQ_JK,
    `LFES_SEQ_LAT, `LFES_SEQ_RS, 4'h5};
  logic [14:0] seq_tab [5] = '{15'h72A7, 15'h53BA, 15'h72A7,
    15'h5285, 15'h60A6};

  lfes_top #(.N(N)) i_dut (.clk, .rst_n, .lut_comb_in, .lut_third_input,
    .lut_third_mask_q, .event_a_in, .event_b_in, .event_a_to_truth,
    .event_b_to_truth, .lut_event_out, .lut_enable, .output_filter_select,
    .edge_detect_enable, .lut_clock_source, .pair_sequencer_select,
    .interrupt_edge_mode, .flag_clear, .lut_interrupt_flag, .irq_q,
    .standby_sleep, .standby_keep_running, .lut_out);

  // Free-running clock
  always #10 clk = ~clk;

  // ********************
  // Checking
  // ********************
  task automatic cmp_bit(input string nm, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", nm, e, s);
    end
  endtask : cmp_bit

  task automatic cmp_vec(input string nm, input logic [N-1:0] e,
                         input logic [N-1:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp_vec

  // Records an expected result for the watcher
  task automatic note(input int kind, input int idx, input logic [N-1:0] e);
    lfes_note_t n;
    n.kind = kind;
    n.idx = idx;
    n.exp = e;
    notes_q.push_back(n);
    -> chk_ev;
    // Let the watcher compare before the inputs move on
    #0;
  endtask : note

  // Watcher takes the oldest note and compares
  always @(chk_ev) begin
    while (notes_q.size() > 0) begin
      cur = notes_q.pop_front();
      case (cur.kind)
        0: cmp_bit("lut_out", cur.exp[0], lut_out[cur.idx]);
        1: cmp_bit("flag", cur.exp[0], lut_interrupt_flag[cur.idx]);
        2: cmp_bit("irq_q", cur.exp[0], irq_q);
        3: cmp_bit("mask", cur.exp[0], lut_third_mask_q[cur.idx]);
        4: cmp_vec("event_a_to_truth", cur.exp, event_a_to_truth);
        5: cmp_vec("event_b_to_truth", cur.exp, event_b_to_truth);
        6: cmp_bit("lut_event_out", cur.exp[0], lut_event_out[cur.idx]);
        default: cmp_vec("edge_pulses", cur.exp, pulses);
      endcase
    end
  end

  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // ********************
  // Stimulus
  // ********************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Counts high cycles of one output
  task automatic cnt_hi(input int idx, input int n);
    pulses = '0;
    repeat (n) begin
      @(negedge clk);
      if (lut_out[idx] === 1'b1) begin
        pulses = pulses + 1'b1;
      end
    end
  endtask : cnt_hi

  // Hang guard
  initial begin : watchdog
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin : main
    seed = $urandom(32'hDBEA);
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    // Configure all LUTs while disabled
    output_filter_select = {`LFES_FILT_SYNC, `LFES_FILT_PERS,
      `LFES_FILT_SYNC, `LFES_FILT_SYNC, `LFES_FILT_NONE, `LFES_FILT_NONE};
    edge_detect_enable = 6'h20;
    lut_clock_source = {6'h00, `LFES_CLK_IN2, 9'h000};
    cyc(2);
    lut_enable = 6'h3E;
    cyc(2);
    note(3, 3, 1);
    note(3, 2, 0);
    // Bypass path and event pass-through
    for (int k = 0; k < 8; k++) begin
      lut_comb_in[1] = 1'($urandom_range(1));
      event_a_in = N'($urandom);
      event_b_in = N'($urandom);
      #1;
      note(0, 1, lut_comb_in[1]);
      note(6, 1, lut_comb_in[1]);
      note(4, 0, event_a_in);
      note(5, 0, event_b_in);
      cyc(1);
    end
    // Synchroniser delay, then a refused filter change
    lut_comb_in[2] = 1'b1;
    cyc(1);
    note(0, 2, 0);
    cyc(1);
    note(0, 2, 1);
    output_filter_select[5:4] = `LFES_FILT_NONE;
    lut_comb_in[2] = 1'b0;
    cyc(1);
    note(0, 2, 1);
    cyc(1);
    note(0, 2, 0);
    // Persistence: short glitch blocked, steady value passes
    lut_comb_in[4] = 1'b1;
    cyc(2);
    lut_comb_in[4] = 1'b0;
    cnt_hi(4, 6);
    note(7, 0, 0);
    lut_comb_in[4] = 1'b1;
    cyc(3);
    note(0, 4, 0);
    cyc(1);
    note(0, 4, 1);
    // Disable clears filter state
    lut_enable[4] = 1'b0;
    cyc(1);
    note(0, 4, 0);
    lut_enable[4] = 1'b1;
    cyc(3);
    note(0, 4, 0);
    // Edge detector: one pulse per rise, none on fall
    lut_comb_in[5] = 1'b1;
    cnt_hi(5, 10);
    note(7, 0, 1);
    lut_enable[5] = 1'b0;
    cyc(2);
    lut_enable[5] = 1'b1;
    cnt_hi(5, 10);
    note(7, 0, 1);
    lut_comb_in[5] = 1'b0;
    cnt_hi(5, 6);
    note(7, 0, 0);
    // Third input as local clock
    lut_comb_in[3] = 1'b1;
    cyc(8);
    note(0, 3, 0);
    repeat (2) begin
      lut_third_input[3] = 1'b1;
      cyc(4);
      lut_third_input[3] = 1'b0;
      cyc(4);
    end
    note(0, 3, 1);
    // Sequencer modes on pair zero
    for (int m = 0; m < 5; m++) begin
      lut_enable[0] = 1'b0;
      lut_comb_in[1:0] = 2'h0;
      cyc(2);
      note(0, 0, 0);
      pair_sequencer_select[3:0] = seq_mode[m];
      cyc(1);
      lut_enable[0] = 1'b1;
      cyc(2);
      for (int s = 0; s < 5; s++) begin
        lut_comb_in[1:0] = {seq_tab[m][13-3*s], seq_tab[m][14-3*s]};
        cyc(1);
        note(0, 0, seq_tab[m][12-3*s]);
      end
    end
    // Interrupt edge modes on LUT one
    for (int m = 0; m < 4; m++) begin
      interrupt_edge_mode[3:2] = 2'(m);
      lut_comb_in[1] = 1'b0;
      flag_clear[1] = 1'b1;
      cyc(3);
      flag_clear[1] = 1'b0;
      cyc(2);
      note(2, 0, 0);
      lut_comb_in[1] = 1'b1;
      cyc(3);
      note(1, 1, m[0]);
      note(2, 0, m[0]);
      flag_clear[1] = 1'b1;
      cyc(1);
      flag_clear[1] = 1'b0;
      cyc(2);
      note(1, 1, 0);
      note(2, 0, 0);
      lut_comb_in[1] = 1'b0;
      cyc(3);
      note(1, 1, m[1]);
      note(2, 0, m[1]);
    end
    // Set beats a clear in the same cycle
    flag_clear[1] = 1'b1;
    lut_comb_in[1] = 1'b1;
    cyc(1);
    note(1, 1, 1);
    flag_clear[1] = 1'b0;
    // Standby forcing and keep-running
    lut_comb_in[2] = 1'b1;
    cyc(3);
    note(0, 2, 1);
    standby_sleep = 1'b1;
    lut_comb_in[1] = 1'b1;
    cyc(1);
    note(0, 2, 0);
    note(0, 1, 1);
    standby_keep_running = 1'b1;
    cyc(1);
    note(0, 2, 1);
    standby_sleep = 1'b0;
    cyc(2);
    close_out();
  end
endmodule : lfes_top_tb_top
